/* File: lvt_serializer.sv */
// Differential transmit serializer channel with APB control
`timescale 1ns/1ns
module lvt_serializer
	import lvt_pkg::*;
(
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              nrst,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Core parallel side
	input  wire logic [WORD_W-1:0] par_data,
	output logic                   par_load,
	// Side PLL and pad cell controls
	output logic [2:0]             pll_phase_step,
	output logic [1:0]             pad_clk_sel,
	// Differential output pair
	output logic                   tx_out_p,
	output logic                   tx_out_n
);

	// ==========================================================
	// Configuration and state registers
	logic              en_q;
	logic [3:0]        fact_q;
	logic [1:0]        mode_q;
	logic              ddr_q;
	logic [2:0]        div_q;
	logic              ph180_q;
	logic [2:0]        step_q;
	logic [1:0]        csrc_q;
	logic              err_q;
	logic              loaded_q;
	logic [3:0]        bit_cnt_q;
	logic [3:0]        div_cnt_q;
	logic              fclk_q;
	logic              byp_hi_q;
	logic              byp_lo_q;
	logic              out_p_q;
	logic              out_n_q;
	logic [15:0]       wcnt_q;
	logic [31:0]       prdata_q;
	logic              err_q_d;

	// ==========================================================
	// Bus decode
	wire               apb_setup  = psel && !penable;
	wire               apb_access = psel && penable;
	wire               hit_ctrl   = (paddr == ADDR_CTRL);
	wire               hit_stat   = (paddr == ADDR_STAT);
	wire               hit_wcnt   = (paddr == ADDR_WCNT);
	wire               hit_any    = hit_ctrl || hit_stat || hit_wcnt;
	wire               wr_ctrl    = apb_access && pwrite && hit_ctrl;

	wire [3:0]         w_fact = pwdata[CTRL_FACT_LO +: 4];
	wire [1:0]         w_mode = pwdata[CTRL_MODE_LO +: 2];
	wire [2:0]         w_div  = pwdata[CTRL_DIV_LO +: 3];

	// Divisor code to ratio minus one: 1, 2, 4, 8, 10
	function automatic logic [3:0] div_m1(input logic [2:0] code);
		case (code)
			3'h0:    div_m1 = 4'h0;
			3'h1:    div_m1 = 4'h1;
			3'h2:    div_m1 = 4'h3;
			3'h3:    div_m1 = 4'h7;
			3'h4:    div_m1 = 4'h9;
			default: div_m1 = 4'hF;
		endcase
	endfunction

	// Ratio must divide the word length
	function automatic logic div_ok(input logic [2:0] code,
	                                input logic [3:0] fact);
		logic [3:0] r;
		r = div_m1(code) + 4'h1;
		if (code > 3'h4)
			div_ok = 1'b0;
		else if (code == 3'h0)
			div_ok = 1'b1;
		else
			div_ok = ((fact % r) == 4'h0);
	endfunction

	wire fact_ok = (w_fact >= FACT_MIN) && (w_fact <= FACT_MAX); // [R4]
	wire mode_ok = (w_mode == MODE_SER) || (w_mode == MODE_BYP) ||
	               ((w_mode == MODE_CLK) && FWD_RATE_OK); // [R7]
	wire cfg_ok  = fact_ok && mode_ok && div_ok(w_div, w_fact); // [R8]
	// Settings only move while the channel is stopped
	wire cfg_wr  = wr_ctrl && !en_q && cfg_ok; // [R4] [R11]
	wire en_wr   = wr_ctrl && (en_q || cfg_ok);
	wire bad_wr  = wr_ctrl && !en_q && !cfg_ok;

	// ==========================================================
	// Mode decode
	lvt_mode_t mode_oh;
	assign mode_oh = (mode_q == MODE_CLK) ? LVT_CLK :
	                 (mode_q == MODE_BYP) ? LVT_BYP : LVT_SER;
	wire is_byp = (mode_oh == LVT_BYP);
	wire is_clk = (mode_oh == LVT_CLK);

	// ==========================================================
	// Word timing
	wire [3:0] eff_m1   = is_byp ? (ddr_q ? 4'h1 : 4'h0)
	                             : (fact_q - 4'h1); // [R12]
	wire       load_stb = en_q && (bit_cnt_q == eff_m1); // [R5]
	wire       xfer     = en_q && loaded_q && (bit_cnt_q == 4'h0);
	wire [3:0] bit_cnt_d = (!en_q || load_stb) ? 4'h0
	                                           : bit_cnt_q + 4'h1;
	wire [3:0] pad_sh   = FACT_MAX - fact_q;
	wire [WORD_W-1:0] par_aligned = par_data << pad_sh;
	wire       lane_bit;
	wire       fwd_wrap = (div_cnt_q == div_m1(div_q));
	wire       fwd_bit  = fclk_q ^ ph180_q; // [R9]
	wire       byp_bit  = (bit_cnt_q == 4'h0) ? byp_hi_q : byp_lo_q;
	wire       out_d    = is_clk ? fwd_bit :
	                      is_byp ? byp_bit : lane_bit; // [R6]

	// Core is expected to hold par_data through the strobe cycle
	assign par_load = load_stb; // [R18]
	assign err_q_d  = bad_wr ? 1'b1 : (cfg_wr ? 1'b0 : err_q);

	lvt_ser_lane u_lane (
		.ref_clk  (ref_clk),
		.nrst     (nrst),
		.load_stb (load_stb && !is_byp && !is_clk),
		.xfer     (xfer),
		.din      (par_aligned),
		.ser_bit  (lane_bit)
	);

	// ==========================================================
	// Configuration register
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			en_q    <= 1'b0;
			fact_q  <= FACT_RST;
			mode_q  <= MODE_RST;
			ddr_q   <= 1'b0;
			div_q   <= DIV_RST;
			ph180_q <= 1'b0;
			step_q  <= STEP_RST;
			csrc_q  <= CSRC_RST;
			err_q   <= 1'b0;
		end else begin
			err_q <= err_q_d;
			if (en_wr) begin
				en_q <= pwdata[CTRL_EN];
			end
			if (cfg_wr) begin
				fact_q  <= w_fact; // [R4]
				mode_q  <= w_mode;
				ddr_q   <= pwdata[CTRL_DDR]; // [R13]
				div_q   <= w_div; // [R8]
				ph180_q <= pwdata[CTRL_PH180]; // [R9]
				step_q  <= pwdata[CTRL_STEP_LO +: 3]; // [R10]
				csrc_q  <= pwdata[CTRL_CSRC_LO +: 2]; // [R14]
			end
		end
	end

	// ==========================================================
	// Bit counter, pad registers, forwarded clock
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			bit_cnt_q <= 4'h0;
			loaded_q  <= 1'b0;
			byp_hi_q  <= 1'b0;
			byp_lo_q  <= 1'b0;
			wcnt_q    <= 16'h0000;
		end else begin
			bit_cnt_q <= bit_cnt_d; // [R5] [R17]
			loaded_q  <= en_q && (loaded_q || load_stb);
			if (load_stb) begin
				wcnt_q <= wcnt_q + 16'h0001;
			end
			if (load_stb && is_byp) begin
				byp_hi_q <= ddr_q ? par_data[1] : par_data[0]; // [R13]
				byp_lo_q <= par_data[0];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			div_cnt_q <= 4'h0;
			fclk_q    <= 1'b0;
		end else if (!en_q || !is_clk) begin
			div_cnt_q <= 4'h0;
			fclk_q    <= 1'b0;
		end else if (fwd_wrap) begin
			div_cnt_q <= 4'h0;
			fclk_q    <= !fclk_q; // [R7] [R8]
		end else begin
			div_cnt_q <= div_cnt_q + 4'h1;
		end
	end

	// ==========================================================
	// Output pair, both legs from flops
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			out_p_q <= 1'b0;
			out_n_q <= 1'b1;
		end else begin
			out_p_q <= en_q && out_d;
			out_n_q <= !(en_q && out_d); // [R16]
		end
	end

	assign tx_out_p       = out_p_q;
	assign tx_out_n       = out_n_q;
	assign pll_phase_step = step_q; // [R10]
	assign pad_clk_sel    = csrc_q; // [R14]

	// ==========================================================
	// APB read path, zero wait states
	wire [31:0] ctrl_rd = {15'h0000, csrc_q, step_q, ph180_q, div_q,
	                       ddr_q, mode_q, fact_q, en_q};
	wire [31:0] stat_rd = {25'h0000000, err_q, bit_cnt_q, loaded_q,
	                       en_q};
	wire [31:0] rd_mux  = hit_ctrl ? ctrl_rd :
	                      hit_stat ? stat_rd :
	                      hit_wcnt ? {16'h0000, wcnt_q} : 32'h00000000;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			prdata_q <= 32'h00000000;
		end else if (apb_setup) begin
			prdata_q <= rd_mux;
		end
	end

	assign prdata  = prdata_q;
	assign pready  = 1'b1;
	assign pslverr = apb_access && !hit_any;

	// ==========================================================
	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	logic [3:0] gap_q;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			gap_q <= 4'h0;
		else
			gap_q <= load_stb ? 4'h0 : gap_q + 4'h1;
	end

	sequence s_load_ser;
		load_stb && !is_byp && !is_clk && $stable(fact_q);
	endsequence
	sequence s_first_bit;
		lane_bit == $past(par_aligned[WORD_W-1], 2);
	endsequence

	a_msb_first_out: assert property ( // [R2]
		s_load_ser ##1 en_q |=> s_first_bit
	) else $error("first serial bit is not the word msb");

	// Spacing counts only once a word was loaded in this run
	a_strobe_spacing: assert property ( // [R5]
		load_stb && loaded_q && $stable(eff_m1) |-> gap_q == eff_m1
	) else $error("load strobe spacing differs from factor");

	a_strobe_to_xfer: assert property ( // [R17]
		load_stb && en_q && eff_m1 != 4'h0 ##1 en_q |-> xfer
	) else $error("loaded word not moved into shift register");

	a_pair_inverse: assert property ( // [R16]
		tx_out_n == !tx_out_p
	) else $error("differential legs not complementary");

	a_cfg_frozen: assert property ( // [R11]
		en_q && $past(en_q) |-> $stable(fact_q) && $stable(div_q) &&
		$stable(ph180_q) && $stable(mode_q)
	) else $error("configuration changed while running");

	a_fact_range: assert property ( // [R4]
		fact_q >= FACT_MIN && fact_q <= FACT_MAX
	) else $error("serialization factor out of range");

	a_fwd_toggle: assert property ( // [R8]
		en_q && is_clk && !fwd_wrap ##1 en_q |-> $stable(fclk_q)
	) else $error("forwarded clock toggled before divider wrap");

	a_fwd_phase: assert property ( // [R9]
		en_q && is_clk ##1 en_q |-> tx_out_p == ($past(fclk_q) ^ ph180_q)
	) else $error("forwarded clock phase mismatch");

	a_byp_order: assert property ( // [R13]
		load_stb && is_byp && ddr_q && en_q ##1 en_q ##1 en_q
		|-> tx_out_p == $past(par_data[1], 2)
	) else $error("bypass double rate order wrong");

	a_bad_cfg_flag: assert property ( // [R8]
		bad_wr |=> err_q && $stable(div_q)
	) else $error("refused setting not flagged");

endmodule // lvt_serializer

/* File: lvt_pkg.sv */
// Constants and types for the differential transmit serializer
// Overview of operation
// R1: Capture up to ten-bit word into load register
// R2: Most significant bit goes out first
// R3: Strobe clocks load, bit clock clocks shift
// R4: Factor three to ten, fixed while running
// R5: Load strobe derived from serialization factor
// R6: Channel may forward a clock instead
// R7: Forwarded clock at data rate, max 800 MHz
// R8: Clock divide 2/4/8/10 by factor
// R9: Clock phase 0 or 180 degrees
// R10: Extra phase shift in 45-degree steps
// R11: Clock rate, divisor, phase fixed while running
// R12: Bypass gives factor two or one
// R13: Two pad output registers, double or single
// R14: Pad registers clock from routing or PLLs
// R15: Emulated outputs driven by general logic
// R16: Second single-ended output drives inverse
// R17: Words shift back to back, no idle
// R18: Core holds word stable during load
package lvt_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0]  ADDR_CTRL   = 8'h00;
	localparam logic [7:0]  ADDR_STAT   = 8'h04;
	localparam logic [7:0]  ADDR_WCNT   = 8'h08;

	// ==========================================================
	// Control field positions
	localparam int CTRL_EN      = 0;
	localparam int CTRL_FACT_LO = 1;
	localparam int CTRL_MODE_LO = 5;
	localparam int CTRL_DDR     = 7;
	localparam int CTRL_DIV_LO  = 8;
	localparam int CTRL_PH180   = 11;
	localparam int CTRL_STEP_LO = 12;
	localparam int CTRL_CSRC_LO = 15;

	// ==========================================================
	// Status field positions
	localparam int STAT_EN      = 0;
	localparam int STAT_LOADED  = 1;
	localparam int STAT_CNT_LO  = 2;
	localparam int STAT_ERR     = 6;

	// ==========================================================
	// Reset values and limits
	localparam logic [3:0]  FACT_MIN    = 4'hA - 4'h7;
	localparam logic [3:0]  FACT_MAX    = 4'hA;
	localparam logic [3:0]  FACT_RST    = 4'hA;
	localparam logic [1:0]  MODE_RST    = 2'h0;
	localparam logic [2:0]  DIV_RST     = 3'h0;
	localparam logic [2:0]  STEP_RST    = 3'h0;
	localparam logic [1:0]  CSRC_RST    = 2'h0;
	localparam int          WORD_W      = 10;

	// Mode field encodings
	localparam logic [1:0]  MODE_SER    = 2'h0;
	localparam logic [1:0]  MODE_CLK    = 2'h1;
	localparam logic [1:0]  MODE_BYP    = 2'h2;

	// ==========================================================
	// Timing
	localparam int CLK_MHZ      = 250;
	localparam int FWD_MAX_MHZ  = 800;
	localparam bit FWD_RATE_OK  = (CLK_MHZ <= FWD_MAX_MHZ);

	// Channel mode, one-hot
	typedef enum logic [2:0] {
		LVT_SER = 3'h1,
		LVT_CLK = 3'h2,
		LVT_BYP = 3'h4
	} lvt_mode_t;

endpackage

/* File: lvt_ser_lane.sv */
// Load register and shift register of one serial lane
`timescale 1ns/1ns
module lvt_ser_lane
	import lvt_pkg::*;
(
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              nrst,
	// Control
	input  wire logic              load_stb,
	input  wire logic              xfer,
	// Data
	input  wire logic [WORD_W-1:0] din,
	output logic                   ser_bit
);

	logic [WORD_W-1:0] load_q;
	logic [WORD_W-1:0] shift_q;
	logic              bit_q;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			load_q  <= '0;
			shift_q <= '0;
			bit_q   <= 1'b0;
		end else begin
			if (load_stb) begin
				load_q <= din; // [R1] [R3]
			end
			if (xfer) begin
				bit_q   <= load_q[WORD_W-1]; // [R2]
				shift_q <= load_q << 1;
			end else begin
				bit_q   <= shift_q[WORD_W-1]; // [R17]
				shift_q <= shift_q << 1;
			end
		end
	end

	assign ser_bit = bit_q;

endmodule // lvt_ser_lane

/* File: lvt_remote_rx.sv */
// Remote receiver model watching the differential pair
`timescale 1ns/1ns
module lvt_remote_rx (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	// Differential pair
	input  wire logic       tx_out_p,
	input  wire logic       tx_out_n,
	// Observations
	output logic [9:0]      rx_sr,
	output int              pair_errs
);
	// Shift in line bits, first bit ends up highest
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rx_sr <= 10'h000;
			pair_errs <= 0;
		end else begin
			rx_sr <= {rx_sr[8:0], tx_out_p};
			if (tx_out_n !== ~tx_out_p)
				pair_errs <= pair_errs + 1;
		end
	end
endmodule // lvt_remote_rx

/* File: lvds_tx_serializer_bench.sv */
// Self-checking bench for the serializer channel
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
	failures++; $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module lvds_tx_serializer_bench
	import lvt_pkg::*;
;
	logic              ref_clk, nrst, psel, penable, pwrite;
	logic [7:0]        paddr;
	logic [31:0]       pwdata, prdata, rd;
	logic              pready, pslverr, par_load, tx_out_p, tx_out_n, er;
	logic [WORD_W-1:0] par_data;
	logic [2:0]        pll_phase_step;
	logic [1:0]        pad_clk_sel;
	logic [9:0]        rx_sr, msk;
	int                failures, n_tests, pair_errs, t;
	typedef struct {logic [3:0] f; logic [9:0] w1; logic [9:0] w2;} lvt_row_t;
	lvt_row_t rows [8] = '{'{4'h3, 10'h005, 10'h002}, '{4'h4, 10'h009, 10'h006},
		'{4'h5, 10'h013, 10'h00C}, '{4'h6, 10'h02D, 10'h012},
		'{4'h7, 10'h05A, 10'h025}, '{4'h8, 10'h0B1, 10'h04E},
		'{4'h9, 10'h16B, 10'h094}, '{4'hA, 10'h2D3, 10'h12C}};

	lvt_serializer dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.par_data(par_data), .par_load(par_load),
		.pll_phase_step(pll_phase_step), .pad_clk_sel(pad_clk_sel),
		.tx_out_p(tx_out_p), .tx_out_n(tx_out_n));
	lvt_remote_rx rx (.ref_clk(ref_clk), .nrst(nrst), .tx_out_p(tx_out_p),
		.tx_out_n(tx_out_n), .rx_sr(rx_sr), .pair_errs(pair_errs));

	// ==========================================================
	// Bus tasks
	task automatic apb(input logic w, input logic [7:0] a,
	                   input logic [31:0] d);
		@(posedge ref_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// Ends on the first access edge that sees pready high
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	// Disable, set fields, then enable
	task automatic cfg(input logic [31:0] v);
		apb(1'b1, ADDR_CTRL, 32'h0);
		apb(1'b1, ADDR_CTRL, v & 32'hFFFFFFFE);
		apb(1'b1, ADDR_CTRL, v);
	endtask
	task automatic count_tog();
		logic p;
		repeat (4) @(negedge ref_clk);
		p = tx_out_p;
		t = 0;
		repeat (8) begin
			@(negedge ref_clk);
			if (tx_out_p !== p)
				t++;
			p = tx_out_p;
		end
	endtask
	task automatic tally_and_finish();
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ==========================================================
	// Clock, watchdog, sequence
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	initial begin
		#200000;
		failures++;
		tally_and_finish();
	end
	initial begin
		failures = 0; n_tests = 0; nrst = 1'b0; psel = 1'b0; penable = 1'b0;
		pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; par_data = 10'h000;
		repeat (12) @(posedge ref_clk);
		`CHK("rst_p", 1'b0, tx_out_p)
		`CHK("rst_n", 1'b1, tx_out_n)
		`CHK("rst_ld", 1'b0, par_load)
		nrst <= 1'b1;
		apb(1'b0, ADDR_CTRL, 32'h0);
		`CHK("ctrl_rst", 32'h00000014, rd)
		foreach (rows[i]) begin
			cfg({27'h0, rows[i].f, 1'b1});
			par_data <= rows[i].w1;
			do begin
				@(negedge ref_clk);
			end while (par_load !== 1'b1);
			@(posedge ref_clk);
			par_data <= rows[i].w2;
			repeat (3) @(negedge ref_clk);
			for (int k = 0; k < 2 * rows[i].f; k++) begin
				if (k < rows[i].f)
					`CHK("bit1", rows[i].w1[rows[i].f-1-k], tx_out_p)
				else
					`CHK("bit2", rows[i].w2[2*rows[i].f-1-k], tx_out_p)
				if (k == rows[i].f - 3)
					`CHK("ld_per", 1'b1, par_load)
				@(negedge ref_clk);
			end
			msk = 10'h3FF >> (10 - rows[i].f);
			`CHK("rx_w2", rows[i].w2 & msk, rx_sr & msk)
		end
		// Enabled writes change only the enable bit
		cfg(32'h0000000B);
		apb(1'b1, ADDR_CTRL, 32'h0000000F);
		apb(1'b0, ADDR_CTRL, 32'h0);
		`CHK("ctrl_lock", 32'h0000000B, rd)
		apb(1'b1, ADDR_CTRL, 32'h0);
		apb(1'b1, ADDR_CTRL, 32'h00000004);
		apb(1'b0, ADDR_STAT, 32'h0);
		`CHK("err", 1'b1, rd[STAT_ERR])
		`CHK("off_p", 1'b0, tx_out_p)
		apb(1'b0, 8'h0C, 32'h0);
		`CHK("unmap_err", 1'b1, er)
		`CHK("unmap_rd", 32'h0, rd)
		// Clock mode, ratio 2, step 5, source 2
		cfg(32'h00015129);
		`CHK("step", 3'h5, pll_phase_step)
		`CHK("csrc", 2'h2, pad_clk_sel)
		count_tog();
		`CHK("div2", 4, t)
		cfg(32'h00000829);
		count_tog();
		`CHK("div1_ph", 8, t)
		`CHK("ph180", 1'b1, tx_out_p)
		// Bypass modes, word driven on the enabling edge
		cfg(32'h000000D5);
		par_data <= 10'h002;
		count_tog();
		`CHK("ddr", 8, t)
		cfg(32'h00000055);
		par_data <= 10'h001;
		count_tog();
		`CHK("sdr_t", 0, t)
		`CHK("sdr_v", 1'b1, tx_out_p)
		`CHK("pair", 0, pair_errs)
		// Reset in mid-run, then count single-rate loads
		@(posedge ref_clk);
		nrst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		`CHK("mrst_p", 1'b0, tx_out_p)
		`CHK("mrst_n", 1'b1, tx_out_n)
		`CHK("mrst_ld", 1'b0, par_load)
		nrst <= 1'b1;
		apb(1'b0, ADDR_CTRL, 32'h0);
		`CHK("mrst_ctrl", 32'h00000014, rd)
		cfg(32'h00000055);
		apb(1'b1, ADDR_CTRL, 32'h0);
		apb(1'b0, ADDR_WCNT, 32'h0);
		`CHK("wcnt", 32'h00000003, rd)
		tally_and_finish();
	end
endmodule // lvds_tx_serializer_bench
